/* File: der_pkg.sv */
// Shared constants and types of the peer event router
`default_nettype none
package der_pkg;

  // ----------------------------------------------------------------
  // Object counts
  // ----------------------------------------------------------------
  localparam int N_CONTACT = 4;
  localparam int N_BUTTON = 4;
  localparam int N_LOCAL_IN = N_CONTACT + N_BUTTON;
  localparam int N_PAGE = 4;
  localparam int N_SLOT = 4;
  localparam int N_KEY = 16;
  localparam int N_DET = N_LOCAL_IN + N_SLOT;
  localparam int N_SWITCHED = 6;
  localparam int N_BLIND = 2;
  localparam int N_OUT_OBJ = N_SWITCHED + N_BLIND;
  localparam int N_GROUP = N_LOCAL_IN + N_PAGE * N_SLOT + N_OUT_OBJ;
  localparam int GRP_PAGE_BASE = N_LOCAL_IN;
  localparam int GRP_OUT_BASE = N_LOCAL_IN + N_PAGE * N_SLOT;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [11:0] ADR_CTRL = 12'h000;
  localparam logic [11:0] ADR_PAGE_MODE = 12'h004;
  localparam logic [11:0] ADR_STATUS = 12'h008;
  localparam logic [11:0] ADR_OUTPUT = 12'h00c;
  localparam logic [11:0] ADR_GROUP_BASE = 12'h100;
  localparam logic [11:0] ADR_BIND_BASE = 12'h200;
  localparam int CTRL_CLEAR_BIT = 0;
  localparam int OUT_UP_LSB = 6;
  localparam int OUT_DOWN_LSB = 8;
  localparam int STAT_LINK_BIT = 0;
  localparam int STAT_FALLBACK_BIT = 1;
  localparam int STAT_DIR_LSB = 2;

  // ----------------------------------------------------------------
  // Reset and clear values
  // ----------------------------------------------------------------
  localparam logic [7:0] GROUP_OFF = 8'h00;
  localparam logic [7:0] GROUP_DEFAULT = 8'h01;
  localparam logic [N_PAGE-1:0] PAGE_MODE_RESET = 4'hf;
  localparam logic [N_BLIND-1:0] DIR_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Event codes and message carrier
  // ----------------------------------------------------------------
  localparam logic [1:0] EVT_ON = 2'h1;
  localparam logic [1:0] EVT_OFF = 2'h2;
  localparam logic [1:0] EVT_TOGGLE = 2'h3;

  typedef struct packed {
    logic valid;
    logic [7:0] group;
    logic [1:0] evt;
  } der_msg_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } der_wb_req_t;

  typedef enum logic [2:0] {
    DET_IDLE = 3'h1,
    DET_HELD = 3'h2,
    DET_LONG = 3'h4
  } der_det_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int SHORT_TIME_MS = 400;
  localparam int SHORT_CYCLES = (SHORT_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int CNT_W = 26;

endpackage
`default_nettype wire

/* File: der_event_router.sv */
// Peer event router: fallback events from inputs to grouped outputs
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module der_event_router #(
  parameter int SHORT_CYCLES = der_pkg::SHORT_CYCLES
) (
  input wire logic clk_i, // 125 MHz clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire der_pkg::der_wb_req_t wb_req_i, // Wishbone request
  output logic wb_ack_o, // Wishbone acknowledge
  output logic [31:0] wb_dat_o, // Wishbone read data
  input wire logic link_up_i, // Central unit link alive
  input wire logic [der_pkg::N_LOCAL_IN-1:0] in_level_i, // Contact and button levels
  input wire logic [der_pkg::N_KEY-1:0] panel_key_i, // Panel key levels
  input wire logic [1:0] panel_page_i, // Page shown, set by gesture
  input wire der_pkg::der_msg_t peer_msg_i, // Message from peer modules
  output der_pkg::der_msg_t peer_msg_o, // Message to peer modules
  output logic [der_pkg::N_SWITCHED-1:0] out_on_o, // Switched outputs
  output logic [der_pkg::N_BLIND-1:0] blind_up_o, // Blind up relays
  output logic [der_pkg::N_BLIND-1:0] blind_down_o, // Blind down relays
  output logic resync_o // Pulse on link return
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] group_mem [der_pkg::N_GROUP];
  logic [3:0] bind_mem [der_pkg::N_PAGE * der_pkg::N_SLOT];
  logic [der_pkg::N_PAGE-1:0] page_mode_reg;
  logic [der_pkg::N_SWITCHED-1:0] on_reg, on_next;
  logic [der_pkg::N_BLIND-1:0] up_reg, up_next;
  logic [der_pkg::N_BLIND-1:0] down_reg, down_next;
  logic [der_pkg::N_BLIND-1:0] dir_reg, dir_next;
  logic link_prev_reg;
  logic resync_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  der_pkg::der_msg_t msg_out_reg;
  der_pkg::der_det_t det_reg [der_pkg::N_DET];
  logic [der_pkg::CNT_W-1:0] cnt_reg [der_pkg::N_DET];
  logic [der_pkg::N_DET-1:0] pend_reg;
  logic [1:0] pend_evt_reg [der_pkg::N_DET];

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic fallback_w = ~link_up_i;
  wire logic wb_req_w = wb_req_i.cyc & wb_req_i.stb;
  wire logic wb_wr_w = wb_req_w & wb_req_i.we & ack_reg;
  wire logic [11:0] adr_w = wb_req_i.adr;
  wire logic hit_ctrl_w = (adr_w == der_pkg::ADR_CTRL);
  wire logic hit_mode_w = (adr_w == der_pkg::ADR_PAGE_MODE);
  wire logic hit_stat_w = (adr_w == der_pkg::ADR_STATUS);
  wire logic hit_out_w = (adr_w == der_pkg::ADR_OUTPUT);
  wire logic hit_grp_w = (adr_w[11:8] == der_pkg::ADR_GROUP_BASE[11:8]) & (adr_w[1:0] == 2'h0)
                         & (adr_w[7:2] < 6'(der_pkg::N_GROUP));
  wire logic hit_bind_w = (adr_w[11:8] == der_pkg::ADR_BIND_BASE[11:8]) & (adr_w[1:0] == 2'h0)
                          & (adr_w[7:2] < 6'(der_pkg::N_PAGE * der_pkg::N_SLOT));
  wire logic [4:0] grp_idx_w = adr_w[6:2];
  wire logic [3:0] bind_idx_w = adr_w[5:2];
  wire logic clear_w = wb_wr_w & hit_ctrl_w & wb_req_i.sel[0]
                       & wb_req_i.dat[der_pkg::CTRL_CLEAR_BIT];
  wire logic out_wr_w = wb_wr_w & hit_out_w & link_up_i;

  wire logic [31:0] status_w = {28'h0, dir_reg, fallback_w, link_up_i};
  wire logic [31:0] outword_w = {22'h0, down_reg, up_reg, on_reg};
  wire logic [31:0] rd_mux_w =
    hit_mode_w ? {28'h0, page_mode_reg} :
    hit_stat_w ? status_w :
    hit_out_w ? outword_w :
    hit_grp_w ? {24'h0, group_mem[grp_idx_w]} :
    hit_bind_w ? {28'h0, bind_mem[bind_idx_w]} :
    32'h0;

  // ----------------------------------------------------------------
  // Wishbone slave: ack one cycle after the request, then drop
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
    end else begin
      ack_reg <= wb_req_w & ~ack_reg;
      dat_reg <= (wb_req_w & ~ack_reg) ? rd_mux_w : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration: groups, slot bindings, page modes
  // ----------------------------------------------------------------
  // Clear is applied before a same-cycle group write, so a write lands.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int g = 0; g < der_pkg::N_GROUP; g++) begin
        group_mem[g] <= der_pkg::GROUP_DEFAULT;
      end
      for (int b = 0; b < der_pkg::N_PAGE * der_pkg::N_SLOT; b++) begin
        bind_mem[b] <= 4'(b);
      end
      page_mode_reg <= der_pkg::PAGE_MODE_RESET;
    end else begin
      if (clear_w) begin
        for (int g = 0; g < der_pkg::N_GROUP; g++) begin
          group_mem[g] <= der_pkg::GROUP_OFF;
        end
      end
      if (wb_wr_w & hit_grp_w & wb_req_i.sel[0]) begin
        group_mem[grp_idx_w] <= wb_req_i.dat[7:0];
      end
      if (wb_wr_w & hit_bind_w & wb_req_i.sel[0]) begin
        bind_mem[bind_idx_w] <= wb_req_i.dat[3:0];
      end
      if (wb_wr_w & hit_mode_w & wb_req_i.sel[0]) begin
        page_mode_reg <= wb_req_i.dat[der_pkg::N_PAGE-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Input event detectors
  // ----------------------------------------------------------------
  // A press is held back until it proves long: a brief one yields only a
  // toggle, so the output never flickers on and back off.
  logic [der_pkg::N_DET-1:0] lvl_w;
  logic [der_pkg::N_DET-1:0] fire_w;
  logic [1:0] evt_w [der_pkg::N_DET];
  logic [7:0] src_grp_w [der_pkg::N_DET];
  logic [der_pkg::N_DET-1:0] gate_w;
  logic [der_pkg::N_DET-1:0] grant_w;

  genvar d;
  generate
    for (d = 0; d < der_pkg::N_DET; d++) begin : g_det
      if (d < der_pkg::N_LOCAL_IN) begin : g_local
        assign lvl_w[d] = in_level_i[d];
        assign src_grp_w[d] = group_mem[d];
        assign gate_w[d] = 1'b1;
      end else begin : g_slot
        localparam logic [1:0] SLOT = 2'(d - der_pkg::N_LOCAL_IN);
        wire logic [4:0] gidx_w = 5'(der_pkg::GRP_PAGE_BASE) + {1'b0, panel_page_i, SLOT};
        assign lvl_w[d] = panel_key_i[bind_mem[{panel_page_i, SLOT}]];
        assign src_grp_w[d] = group_mem[gidx_w];
        assign gate_w[d] = page_mode_reg[panel_page_i];
      end

      wire logic long_w = (cnt_reg[d] == der_pkg::CNT_W'(SHORT_CYCLES - 1));
      assign fire_w[d] = ((det_reg[d] == der_pkg::DET_HELD) & (~lvl_w[d] | long_w))
                         | ((det_reg[d] == der_pkg::DET_LONG) & ~lvl_w[d]);
      assign evt_w[d] = (det_reg[d] == der_pkg::DET_LONG) ? der_pkg::EVT_OFF :
                        lvl_w[d] ? der_pkg::EVT_ON : der_pkg::EVT_TOGGLE;

      always_ff @(posedge clk_i) begin
        if (rst_i | ~gate_w[d]) begin
          det_reg[d] <= der_pkg::DET_IDLE;
          cnt_reg[d] <= '0;
        end else begin
          unique case (det_reg[d])
            der_pkg::DET_IDLE: begin
              cnt_reg[d] <= '0;
              if (lvl_w[d]) begin
                det_reg[d] <= der_pkg::DET_HELD;
              end
            end
            der_pkg::DET_HELD: begin
              cnt_reg[d] <= cnt_reg[d] + der_pkg::CNT_W'(1);
              if (~lvl_w[d]) begin
                det_reg[d] <= der_pkg::DET_IDLE;
              end else if (long_w) begin
                det_reg[d] <= der_pkg::DET_LONG;
              end
            end
            der_pkg::DET_LONG: begin
              if (~lvl_w[d]) begin
                det_reg[d] <= der_pkg::DET_IDLE;
              end
            end
            default: begin
              det_reg[d] <= der_pkg::DET_IDLE;
            end
          endcase
        end
      end

      // Pending event per source; a new event beats its own grant.
      wire logic take_w = fire_w[d] & gate_w[d] & fallback_w
                          & (src_grp_w[d] != der_pkg::GROUP_OFF);
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          pend_reg[d] <= 1'b0;
          pend_evt_reg[d] <= 2'h0;
        end else if (take_w) begin
          pend_reg[d] <= 1'b1;
          pend_evt_reg[d] <= evt_w[d];
        end else if (grant_w[d] | ~fallback_w) begin
          pend_reg[d] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Arbitration: peer message first, then lowest pending source
  // ----------------------------------------------------------------
  // Only one message moves per cycle, matching a single shared bus slot.
  wire logic peer_in_w = peer_msg_i.valid & fallback_w;
  wire logic [der_pkg::N_DET-1:0] pend_live_w = pend_reg & {der_pkg::N_DET{~peer_in_w}};
  assign grant_w = pend_live_w & (~pend_live_w + der_pkg::N_DET'(1));

  der_pkg::der_msg_t local_msg_w;
  always_comb begin
    local_msg_w = '0;
    for (int s = 0; s < der_pkg::N_DET; s++) begin
      if (grant_w[s]) begin
        local_msg_w.valid = 1'b1;
        local_msg_w.group = src_grp_w[s];
        local_msg_w.evt = pend_evt_reg[s];
      end
    end
  end

  wire der_pkg::der_msg_t apply_w = peer_in_w ? peer_msg_i : local_msg_w;

  // ----------------------------------------------------------------
  // Output actions
  // ----------------------------------------------------------------
  always_comb begin
    on_next = on_reg;
    up_next = up_reg;
    down_next = down_reg;
    dir_next = dir_reg;
    if (out_wr_w) begin
      if (wb_req_i.sel[0]) begin
        on_next = wb_req_i.dat[der_pkg::N_SWITCHED-1:0];
        up_next = wb_req_i.dat[der_pkg::OUT_UP_LSB +: der_pkg::N_BLIND];
      end
      if (wb_req_i.sel[1]) begin
        down_next = wb_req_i.dat[der_pkg::OUT_DOWN_LSB +: der_pkg::N_BLIND]
                    & ~up_next;
      end
    end else if (apply_w.valid & fallback_w) begin
      for (int o = 0; o < der_pkg::N_SWITCHED; o++) begin
        if ((group_mem[der_pkg::GRP_OUT_BASE + o] == apply_w.group)
            && (apply_w.group != der_pkg::GROUP_OFF)) begin
          unique case (apply_w.evt)
            der_pkg::EVT_ON: on_next[o] = 1'b1;
            der_pkg::EVT_OFF: on_next[o] = 1'b0;
            der_pkg::EVT_TOGGLE: on_next[o] = ~on_reg[o];
            default: on_next[o] = on_reg[o];
          endcase
        end
      end
      for (int k = 0; k < der_pkg::N_BLIND; k++) begin
        if ((group_mem[der_pkg::GRP_OUT_BASE + der_pkg::N_SWITCHED + k] == apply_w.group)
            && (apply_w.group != der_pkg::GROUP_OFF)) begin
          unique case (apply_w.evt)
            der_pkg::EVT_ON: begin
              if (~up_reg[k] & ~down_reg[k]) begin
                up_next[k] = dir_reg[k];
                down_next[k] = ~dir_reg[k];
              end
            end
            der_pkg::EVT_OFF: begin
              up_next[k] = 1'b0;
              down_next[k] = 1'b0;
            end
            der_pkg::EVT_TOGGLE: begin
              up_next[k] = ~(up_reg[k] | down_reg[k]) & dir_reg[k];
              down_next[k] = ~(up_reg[k] | down_reg[k]) & ~dir_reg[k];
            end
            default: begin
              up_next[k] = up_reg[k];
            end
          endcase
        end
      end
    end
    for (int k = 0; k < der_pkg::N_BLIND; k++) begin
      if (up_next[k]) begin
        dir_next[k] = 1'b1;
      end else if (down_next[k]) begin
        dir_next[k] = 1'b0;
      end
    end
  end

  // No drive timer exists on the relays: in fallback they hold until an
  // event releases them, and software takes them over on link return.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      on_reg <= '0;
      up_reg <= '0;
      down_reg <= '0;
      dir_reg <= der_pkg::DIR_RESET;
    end else begin
      on_reg <= on_next;
      up_reg <= up_next;
      down_reg <= down_next;
      dir_reg <= dir_next;
    end
  end

  // ----------------------------------------------------------------
  // Peer message out and link return
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      msg_out_reg <= '0;
      link_prev_reg <= 1'b0;
      resync_reg <= 1'b0;
    end else begin
      msg_out_reg <= local_msg_w;
      link_prev_reg <= link_up_i;
      resync_reg <= link_up_i & ~link_prev_reg;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign peer_msg_o = msg_out_reg;
  assign out_on_o = on_reg;
  assign blind_up_o = up_reg;
  assign blind_down_o = down_reg;
  assign resync_o = resync_reg;

endmodule // der_event_router
`default_nettype wire

/* File: der_event_router_asserts.sv */
// Concurrent checks on the peer event router ports
`timescale 1ns/10ps
`default_nettype none
module der_router_asserts #(
  parameter int SHORT_CYCLES = der_pkg::SHORT_CYCLES
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire der_pkg::der_wb_req_t wb_req_i, // Bus request
  input wire logic wb_ack_o, // Bus ack
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic link_up_i, // Link alive
  input wire der_pkg::der_msg_t peer_msg_i, // Peer message in
  input wire der_pkg::der_msg_t peer_msg_o, // Peer message out
  input wire logic [der_pkg::N_SWITCHED-1:0] out_on_o, // Switched outputs
  input wire logic [der_pkg::N_BLIND-1:0] blind_up_o, // Up relays
  input wire logic [der_pkg::N_BLIND-1:0] blind_down_o, // Down relays
  input wire logic resync_o // Link return pulse
);
  wire logic req = wb_req_i.cyc & wb_req_i.stb;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ------
  // Steps
  // ------
  sequence link_back;
    !link_up_i ##1 link_up_i;
  endsequence
  // In fallback, outputs may only move with a message out or on the sample after a message in
  sequence quiet_fallback;
    !link_up_i && !$past(link_up_i) && !peer_msg_o.valid && !$past(peer_msg_i.valid);
  endsequence
  a_ack_latency: assert property (req && !wb_ack_o && !$past(req) |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_relay_excl: assert property ((blind_up_o & blind_down_o) == '0)
    else $error("both blind relays on");
  a_linkup_silent: assert property (link_up_i && $past(link_up_i) && $past(link_up_i, 2)
    |-> !peer_msg_o.valid) else $error("peer message while link up");
  a_msg_fields: assert property (peer_msg_o.valid |-> peer_msg_o.group != 8'h00
    && peer_msg_o.evt != 2'h0) else $error("message with zero group or code");
  a_resync_after: assert property (link_back |-> ##[1:3] resync_o)
    else $error("no resync pulse on link return");
  a_resync_pulse: assert property (resync_o |=> !resync_o)
    else $error("resync longer than one cycle");
  a_fallback_hold: assert property (quiet_fallback |-> $stable(out_on_o)
    && $stable(blind_up_o) && $stable(blind_down_o)) else $error("output moved unasked");
endmodule // der_router_asserts
bind der_event_router der_router_asserts #(.SHORT_CYCLES(SHORT_CYCLES)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o), .link_up_i(link_up_i), .peer_msg_i(peer_msg_i),
  .peer_msg_o(peer_msg_o), .out_on_o(out_on_o), .blind_up_o(blind_up_o),
  .blind_down_o(blind_down_o), .resync_o(resync_o));
`default_nettype wire

/* File: der_peer_model.sv */
// Peer module model on the shared event bus
`timescale 1ns/10ps
`default_nettype none
module der_peer_model (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic send_i, // Send one message
  input wire logic [7:0] grp_i, // Group to send
  input wire logic [1:0] evt_i, // Event to send
  input wire der_pkg::der_msg_t rx_i, // Message from router
  output der_pkg::der_msg_t tx_o, // Message to router
  output int rx_count_o // Messages heard
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_o <= '0;
      rx_count_o <= 0;
    end else begin
      // Fields mean nothing between pulses, so they never repeat the last one
      tx_o <= send_i ? {1'b1, grp_i, evt_i} : {1'b0, ~tx_o.group, ~tx_o.evt};
      if (rx_i.valid) rx_count_o <= rx_count_o + 1;
    end
  end
endmodule // der_peer_model
`default_nettype wire

/* File: tb_distributed_event_router.sv */
// Self-checking bench for the peer event router
`timescale 1ns/10ps
`default_nettype none
module tb_distributed_event_router;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic link_up_i = 1'b1;
  logic [7:0] in_level_i = 8'h00;
  logic [15:0] panel_key_i = 16'h0000;
  logic [1:0] panel_page_i = 2'h0;
  logic send = 1'b0;
  logic [7:0] send_grp = 8'h00;
  logic [1:0] send_evt = 2'h0;
  der_pkg::der_wb_req_t req = '0;
  der_pkg::der_msg_t pm_in, pm_out;
  logic wb_ack_o, resync_o;
  logic [31:0] wb_dat_o, q;
  logic [5:0] out_on_o;
  logic [1:0] up_o, dn_o;
  int bad_count = 0, samples_checked = 0, cycles = 0, ev_n = 0, rx_n, g;
  int grp[32], on[6], up[2], dn[2], dir[2];
  logic [11:0] ra[8] = '{12'h100, 12'h120, 12'h15c, 12'h178, 12'h004, 12'h214, 12'h300, 12'h008};
  logic [31:0] rv[8] = '{32'h1, 32'h1, 32'h1, 32'h1, 32'hf, 32'h5, 32'h0, 32'h1};
  // Groups bound for the fallback scenarios: contact, output, blind, two panel slots
  int gi[5] = '{1, 25, 31, 8, 17};
  always #4 clk_i = ~clk_i;
  der_event_router #(.SHORT_CYCLES(16)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .link_up_i(link_up_i), .in_level_i(in_level_i),
    .panel_key_i(panel_key_i), .panel_page_i(panel_page_i), .peer_msg_i(pm_in),
    .peer_msg_o(pm_out), .out_on_o(out_on_o), .blind_up_o(up_o), .blind_down_o(dn_o),
    .resync_o(resync_o));
  der_peer_model u_peer (.clk_i(clk_i), .rst_i(rst_i), .send_i(send), .grp_i(send_grp),
    .evt_i(send_evt), .rx_i(pm_out), .tx_o(pm_in), .rx_count_o(rx_n));
  // ------
  // Tasks
  // ------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Waits for ack with no limit of its own: the cycle ceiling ends a hang
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    req <= '0;
    @(posedge clk_i);
  endtask
  function automatic logic [31:0] outs();
    logic [31:0] v;
    v = '0;
    for (int i = 0; i < 6; i++) v[i] = on[i][0];
    for (int j = 0; j < 2; j++) v[6+j] = up[j][0];
    for (int j = 0; j < 2; j++) v[8+j] = dn[j][0];
    return v;
  endfunction
  task automatic apply(input int gr, input int e);
    for (int i = 0; i < 6; i++)
      if (gr != 0 && grp[24+i] == gr) on[i] = (e == 3) ? 1 - on[i] : (e == 1);
    for (int j = 0; j < 2; j++)
      if (gr != 0 && grp[30+j] == gr) begin
        if (e == 2 || (e == 3 && up[j] + dn[j] > 0)) begin
          up[j] = 0;
          dn[j] = 0;
        end else if (up[j] + dn[j] == 0) begin
          up[j] = dir[j];
          dn[j] = 1 - dir[j];
        end
      end
  endtask
  task automatic look();
    chk("outputs", {22'h0, dn_o, up_o, out_on_o}, outs());
  endtask
  task automatic ev(input int e, input int gr);
    do begin
      @(posedge clk_i);
    end while (pm_out.valid !== 1'b1);
    chk("event", {22'h0, pm_out.group, pm_out.evt}, {22'h0, gr[7:0], e[1:0]});
    apply(gr, e);
    ev_n++;
    look();
  endtask
  task automatic tap(input int b, input int h);
    if (b < 8) in_level_i[b] <= 1'b1;
    else panel_key_i[b-8] <= 1'b1;
    repeat (h) @(posedge clk_i);
    if (b < 8) in_level_i[b] <= 1'b0;
    else panel_key_i[b-8] <= 1'b0;
  endtask
  task automatic quiet();
    repeat (30) @(posedge clk_i);
    chk("messages", rx_n, ev_n);
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  // ------
  // Sequence
  // ------
  initial begin
    void'($urandom(32'he98f));
    foreach (grp[i]) grp[i] = 1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (ra[i]) begin
      wb(1'b0, ra[i], 32'h0);
      chk("reset read", q, rv[i]);
    end
    wb(1'b1, 12'h00c, 32'h85);
    on[0] = 1;
    on[2] = 1;
    up[1] = 1;
    dir[1] = 1;
    wb(1'b0, 12'h00c, 32'h0);
    chk("output reg", q, outs());
    wb(1'b1, 12'h00c, 32'h0);
    on = '{default: 0};
    up[1] = 0;
    tap(0, 4);
    quiet();
    link_up_i <= 1'b0;
    in_level_i[4] <= 1'b1;
    ev(1, 1);
    repeat (40) @(posedge clk_i);
    look();
    in_level_i[4] <= 1'b0;
    ev(2, 1);
    tap(0, 2 + $urandom % 8);
    ev(3, 1);
    wb(1'b0, 12'h008, 32'h0);
    chk("status", q, 32'h0a);
    tap(3, 2 + $urandom % 8);
    ev(3, 1);
    wb(1'b1, 12'h00c, 32'h3f);
    look();
    link_up_i <= 1'b1;
    wb(1'b1, 12'h000, 32'h1);
    foreach (grp[i]) grp[i] = 0;
    wb(1'b0, 12'h100, 32'h0);
    chk("group cleared", q, 32'h0);
    g = 2 + $urandom % 200;
    foreach (gi[i]) begin
      wb(1'b1, 12'h100 + 12'(4 * gi[i]), g);
      grp[gi[i]] = g;
    end
    wb(1'b0, 12'h164, 32'h0);
    chk("group write", q, g);
    link_up_i <= 1'b0;
    tap(1, 3);
    ev(3, g);
    tap(0, 3);
    quiet();
    for (int e = 1; e < 4; e++) begin
      send_grp <= g[7:0];
      send_evt <= e[1:0];
      send <= 1'b1;
      @(posedge clk_i);
      send <= 1'b0;
      repeat (4) @(posedge clk_i);
      apply(g, e);
      look();
    end
    wb(1'b1, 12'h004, 32'he);
    tap(8, 3);
    quiet();
    wb(1'b1, 12'h004, 32'hf);
    tap(8, 3);
    ev(3, g);
    // Rebind page 2 slot 1 to key 3 and reach it by a page change
    wb(1'b1, 12'h224, 32'h3);
    panel_page_i <= 2'h2;
    tap(11, 3);
    ev(3, g);
    link_up_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("resync", {31'h0, resync_o}, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("resync end", {31'h0, resync_o}, 32'h0);
    wb(1'b0, 12'h00c, 32'h0);
    chk("output after return", q, outs());
    stop_test();
  end
endmodule // tb_distributed_event_router
`default_nettype wire
